// ===== design/spmw_port.v
// Serial port with master/slave modes and match wake
`timescale 1ns/1ps
`default_nettype none
`include "spmw_defs.vh"
module spmw_port
(
   input  wire       core_clk,
   input  wire       rst,
   input  wire [7:0] reg_addr,
   input  wire [7:0] reg_wdata,
   input  wire       reg_wr,
   input  wire       reg_rd,
   output reg  [7:0] reg_rdata,
   input  wire       timer_clock,
   input  wire       first_counter_timer,
   input  wire       sw_irq_set,
   input  wire       serial_input_pin,
   input  wire       select_n_pin,
   input  wire       serial_clock_pin_in,
   output reg        serial_clock_pin_out,
   output reg        serial_clock_pin_oe,
   output reg        serial_output_pin,
   output reg        serial_output_oe,
   output reg        receive_interrupt_request,
   output reg        stop_wake_signal
);
   localparam ST_IDLE   = 2'h0;
   localparam ST_SHIFT  = 2'h1;
   localparam ST_IGNORE = 2'h2;

   reg  [7:0] serial_port_control;
   reg  [7:0] serial_match_value;
   reg  [7:0] receive_holding_buffer;
   reg        byte_ready_flag;
   reg        receive_overrun_flag;
   reg  [1:0] state;
   reg  [7:0] shifter;
   reg  [3:0] bit_cnt;
   reg        cmp_phase;
   reg        sck_q;
   reg  [3:0] div_cnt;
   reg        timer_clock_q;
   reg        tmr_q;
   reg        int_sck;
   reg        next_int_sck;
   wire       din_s;
   wire       ss_n_s;
   wire       sck_s;
   wire       timer_clock_s;
   wire       tmr_s;
   wire       en;
   wire       master;
   wire       phase;
   wire       sck_now;
   wire       rise;
   wire       fall;
   wire       sample_edge;
   wire       drive_edge;
   wire       byte_done;
   wire       fifo_in_ready;
   wire       fifo_out_valid;
   wire [7:0] fifo_out_data;
   wire       ctrl_wr;
   wire       buf_rd;
   wire       src_tick;
   wire [7:0] rx_byte;

   function [3:0] div_limit;
      input [1:0] sel;
      begin
         case (sel)
            2'h0:    div_limit = 4'h0;
            2'h1:    div_limit = 4'h1;
            2'h2:    div_limit = 4'h3;
            default: div_limit = 4'h7;
         endcase
      end
   endfunction

   spmw_sync u_sync_din
   (
      .core_clk (core_clk),
      .rst      (rst),
      .d        (serial_input_pin),
      .q        (din_s)
   );
   spmw_sync u_sync_ss
   (
      .core_clk (core_clk),
      .rst      (rst),
      .d        (select_n_pin),
      .q        (ss_n_s)
   );
   spmw_sync u_sync_sck
   (
      .core_clk (core_clk),
      .rst      (rst),
      .d        (serial_clock_pin_in),
      .q        (sck_s)
   );
   spmw_sync u_sync_timer_clock
   (
      .core_clk (core_clk),
      .rst      (rst),
      .d        (timer_clock),
      .q        (timer_clock_s)
   );
   spmw_sync u_sync_tmr
   (
      .core_clk (core_clk),
      .rst      (rst),
      .d        (first_counter_timer),
      .q        (tmr_s)
   );

   assign en      = serial_port_control[`SPMW_BIT_EN];
   assign master  = serial_port_control[`SPMW_BIT_MASTER];
   assign phase   = serial_port_control[`SPMW_BIT_PHASE];
   assign ctrl_wr = reg_wr && (reg_addr == `SPMW_CTRL_OFFSET);
   assign buf_rd  = reg_rd && (reg_addr == `SPMW_RECEIVE_HOLDING_BUFFER_OFFSET);
   // Timer output or timer clock, divided by the rate bits, drives the master clock
   assign src_tick = serial_port_control[`SPMW_BIT_SRC] ?
                     (tmr_s & ~tmr_q) : (timer_clock_s & ~timer_clock_q);
   // Master uses its own clock, slave the pin
   assign sck_now = master ? int_sck : sck_s;
   assign rise    = sck_now & ~sck_q;
   assign fall    = ~sck_now & sck_q;
   assign sample_edge = phase ? fall : rise;
   assign drive_edge  = phase ? rise : fall;
   assign rx_byte   = {shifter[6:0], din_s};
   assign byte_done = (state == ST_SHIFT) && sample_edge &&
                      (bit_cnt == `SPMW_BITS_PER_BYTE - 4'h1);

   // Drains at once into the holding buffer; slow software reads still overrun in slave mode
   spmw_fifo
   #(
      .WIDTH (`SPMW_FIFO_WIDTH),
      .DEPTH (`SPMW_FIFO_DEPTH),
      .AW    (`SPMW_FIFO_AW)
   )
   u_fifo
   (
      .core_clk  (core_clk),
      .rst       (rst),
      .in_valid  (byte_done && !cmp_phase),
      .in_ready  (fifo_in_ready),
      .in_data   (rx_byte),
      .out_valid (fifo_out_valid),
      .out_ready (1'b1),
      .out_data  (fifo_out_data)
   );

   always @*
   begin
      next_int_sck = int_sck;
      if (master && state == ST_SHIFT && src_tick &&
          div_cnt == div_limit(serial_port_control[2:1]))
         next_int_sck = ~int_sck;
      else if (state != ST_SHIFT)
         next_int_sck = phase;
   end

   always @(posedge core_clk)
   begin
      if (rst)
      begin
         serial_port_control <= `SPMW_CTRL_RESET;
         serial_match_value  <= `SPMW_MATCH_RESET;
         receive_holding_buffer <= 8'h00;
         byte_ready_flag      <= 1'b0;
         receive_overrun_flag <= 1'b0;
         state     <= ST_IDLE;
         shifter   <= 8'h00;
         bit_cnt   <= 4'h0;
         cmp_phase <= 1'b0;
         sck_q     <= 1'b0;
         div_cnt   <= 4'h0;
         timer_clock_q    <= 1'b0;
         tmr_q     <= 1'b0;
         int_sck   <= 1'b0;
         serial_clock_pin_out <= 1'b0;
         serial_clock_pin_oe  <= 1'b0;
         serial_output_pin    <= 1'b0;
         serial_output_oe     <= 1'b0;
         receive_interrupt_request <= 1'b0;
         stop_wake_signal <= 1'b0;
         reg_rdata <= 8'h00;
      end
      else
      begin
         timer_clock_q  <= timer_clock_s;
         tmr_q   <= tmr_s;
         sck_q   <= sck_now;
         int_sck <= next_int_sck;
         stop_wake_signal <= 1'b0;
         if (master && state == ST_SHIFT && src_tick)
            div_cnt <= (div_cnt == div_limit(serial_port_control[2:1])) ?
                       4'h0 : div_cnt + 4'h1;
         else if (state != ST_SHIFT)
            div_cnt <= 4'h0;

         // Register writes
         if (ctrl_wr)
         begin
            serial_port_control <= {reg_wdata[7:5], 1'b0, reg_wdata[3:0]};
            // Overrun clears only by a zero written in slave mode
            if (!master && !reg_wdata[`SPMW_BIT_OVR])
               receive_overrun_flag <= 1'b0;
         end
         if (reg_wr && reg_addr == `SPMW_MATCH_OFFSET)
            serial_match_value <= reg_wdata;

         // Buffer read releases the byte
         if (buf_rd)
            byte_ready_flag <= 1'b0;
         if (fifo_out_valid)
         begin
            receive_holding_buffer <= fifo_out_data;
            byte_ready_flag <= 1'b1;
            if (byte_ready_flag && !buf_rd && !master)
               receive_overrun_flag <= 1'b1;
         end

         // Interrupt: hardware source only while enabled
         if (en && fifo_out_valid)
            receive_interrupt_request <= 1'b1;
         else if (sw_irq_set)
            receive_interrupt_request <= 1'b1;
         else if (buf_rd)
            receive_interrupt_request <= 1'b0;

         case (reg_addr)
            `SPMW_CTRL_OFFSET:
               reg_rdata <= {serial_port_control[7:5], byte_ready_flag,
                             serial_port_control[3:2],
                             master ? serial_port_control[1]
                                    : receive_overrun_flag,
                             serial_port_control[0]};
            `SPMW_MATCH_OFFSET: reg_rdata <= serial_match_value;
            `SPMW_RECEIVE_HOLDING_BUFFER_OFFSET: reg_rdata <= receive_holding_buffer;
            default:            reg_rdata <= 8'h00;
         endcase

         case (state)
            ST_IDLE:
            begin
               bit_cnt <= 4'h0;
               if (!en)
                  serial_output_oe <= 1'b0;
               else if (master && reg_wr &&
                        reg_addr == `SPMW_RECEIVE_HOLDING_BUFFER_OFFSET)
               begin
                  shifter   <= reg_wdata;
                  cmp_phase <= 1'b0;
                  state     <= ST_SHIFT;
                  serial_output_pin <= reg_wdata[7];
                  serial_output_oe  <= 1'b1;
               end
               else if (!master && !ss_n_s)
               begin
                  // Compare byte is silent to avoid bus contention
                  cmp_phase <= serial_port_control[`SPMW_BIT_CMP];
                  state     <= ST_SHIFT;
                  serial_output_pin <= shifter[7];
                  serial_output_oe  <=
                     ~serial_port_control[`SPMW_BIT_CMP] &
                     ~serial_port_control[`SPMW_BIT_DOOFF];
               end
               else
                  serial_output_oe <= 1'b0;
            end
            ST_SHIFT:
            begin
               if (!en || (!master && ss_n_s))
               begin
                  state <= ST_IDLE;
                  serial_output_oe <= 1'b0;
               end
               else
               begin
                  if (sample_edge)
                  begin
                     shifter <= rx_byte;
                     bit_cnt <= bit_cnt + 4'h1;
                  end
                  if (drive_edge && bit_cnt != 4'h0)
                     serial_output_pin <= shifter[7];
                  if (byte_done)
                  begin
                     bit_cnt <= 4'h0;
                     if (cmp_phase)
                     begin
                        cmp_phase <= 1'b0;
                        if (rx_byte == serial_match_value)
                        begin
                           // Not gated by other recovery sources
                           stop_wake_signal <= 1'b1;
                           serial_output_oe <=
                              ~serial_port_control[`SPMW_BIT_DOOFF];
                        end
                        else
                           state <= ST_IGNORE;
                     end
                     else if (master)
                     begin
                        state <= ST_IDLE;
                        serial_output_oe <= 1'b0;
                     end
                  end
               end
            end
            ST_IGNORE:
            begin
               serial_output_oe <= 1'b0;
               if (ss_n_s || !en)
                  state <= ST_IDLE;
            end
            default:
               state <= ST_IDLE;
         endcase
         // Pin leads the edge detector so replies clear the synchroniser
         serial_clock_pin_out <= next_int_sck;
         serial_clock_pin_oe  <= en & master;
      end
   end
endmodule
`default_nettype wire

// ===== design/spmw_defs.vh
// Constants for the serial port with match wake
`ifndef SPMW_DEFS_VH
`define SPMW_DEFS_VH
`define SPMW_CTRL_OFFSET   8'h02
`define SPMW_MATCH_OFFSET  8'h03
`define SPMW_RECEIVE_HOLDING_BUFFER_OFFSET  8'h04
`define SPMW_CTRL_RESET    8'h00
`define SPMW_MATCH_RESET   8'h00
`define SPMW_BIT_EN        0
`define SPMW_BIT_DIV0      1
`define SPMW_BIT_DIV1      2
`define SPMW_BIT_OVR       1
`define SPMW_BIT_DOOFF     2
`define SPMW_BIT_CMP       3
`define SPMW_BIT_RDY       4
`define SPMW_BIT_PHASE     5
`define SPMW_BIT_SRC       6
`define SPMW_BIT_MASTER    7
`define SPMW_FIFO_WIDTH    8
`define SPMW_FIFO_DEPTH    16
`define SPMW_FIFO_AW       4
`define SPMW_BITS_PER_BYTE 4'h8
`endif

// ===== design/spmw_sync.v
// Two-flop synchroniser for pin inputs
`timescale 1ns/1ps
`default_nettype none
module spmw_sync
(
   input  wire core_clk,
   input  wire rst,
   input  wire d,
   output reg  q
);
   reg meta;
   always @(posedge core_clk)
   begin
      if (rst)
      begin
         meta <= 1'b0;
         q    <= 1'b0;
      end
      else
      begin
         meta <= d;
         q    <= meta;
      end
   end
endmodule
`default_nettype wire

// ===== design/spmw_fifo.v
// Parameterised FIFO between shifter and receive buffer
`timescale 1ns/1ps
`default_nettype none
module spmw_fifo
#(
   parameter WIDTH = 8,
   parameter DEPTH = 16,
   parameter AW    = 4
)
(
   input  wire             core_clk,
   input  wire             rst,
   input  wire             in_valid,
   output wire             in_ready,
   input  wire [WIDTH-1:0] in_data,
   output wire             out_valid,
   input  wire             out_ready,
   output wire [WIDTH-1:0] out_data
);
   reg [WIDTH-1:0] mem [0:DEPTH-1];
   reg [AW-1:0]    wr_ptr;
   reg [AW-1:0]    rd_ptr;
   reg [AW:0]      count;
   wire            do_wr;
   wire            do_rd;
   assign in_ready  = (count != DEPTH[AW:0]);
   assign out_valid = (count != {(AW+1){1'b0}});
   assign out_data  = mem[rd_ptr];
   assign do_wr     = in_valid & in_ready;
   assign do_rd     = out_valid & out_ready;
   always @(posedge core_clk)
   begin
      if (do_wr)
         mem[wr_ptr] <= in_data;
   end
   always @(posedge core_clk)
   begin
      if (rst)
      begin
         wr_ptr <= {AW{1'b0}};
         rd_ptr <= {AW{1'b0}};
         count  <= {(AW+1){1'b0}};
      end
      else
      begin
         if (do_wr)
            wr_ptr <= wr_ptr + 1'b1;
         if (do_rd)
            rd_ptr <= rd_ptr + 1'b1;
         if (do_wr && !do_rd)
            count <= count + 1'b1;
         else if (do_rd && !do_wr)
            count <= count - 1'b1;
      end
   end
endmodule
`default_nettype wire

// ===== test/spmw_port_sva.sv
// Assertions on the serial port pins and register strobes
`timescale 1ns/1ps
`default_nettype none
module spmw_port_chk
(
   input wire logic       core_clk,
   input wire logic       rst,
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic       reg_wr,
   input wire logic       reg_rd,
   input wire logic       sw_irq_set,
   input wire logic       serial_clock_pin_oe,
   input wire logic       serial_output_oe,
   input wire logic       receive_interrupt_request,
   input wire logic       stop_wake_signal
);
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (rst);
   logic en;
   logic mst;
   wire  rd_buf = reg_rd && reg_addr == 8'h04;
   // Shadow of enable and role, so pin rules need no internal probes
   always @(posedge core_clk)
   begin
      if (rst)
      begin
         en  <= 1'b0;
         mst <= 1'b0;
      end
      else if (reg_wr && reg_addr == 8'h02)
      begin
         en  <= reg_wdata[0];
         mst <= reg_wdata[7];
      end
   end
   chk_reset_quiet: assert property (disable iff (1'b0)
      rst |=> !receive_interrupt_request && !stop_wake_signal
         && !serial_output_oe && !serial_clock_pin_oe)
      else $error("outputs active after reset");
   chk_off_no_drive: assert property (
      !en && !$past(en) && !$past(en, 2)
         |-> !serial_output_oe && !serial_clock_pin_oe)
      else $error("disabled port drives a pin");
   chk_slave_clk_in: assert property (
      !mst && !$past(mst) && !$past(mst, 2) |-> !serial_clock_pin_oe)
      else $error("slave drives the clock pin");
   chk_irq_holds: assert property (
      receive_interrupt_request && !rd_buf && !$past(rd_buf)
         |=> receive_interrupt_request)
      else $error("interrupt dropped without buffer read");
   chk_read_clears: assert property (
      rd_buf |=> ##[0:1] !receive_interrupt_request)
      else $error("buffer read left interrupt set");
   chk_soft_irq: assert property (
      sw_irq_set |=> ##[0:1] receive_interrupt_request)
      else $error("software interrupt not raised");
   chk_wake_pulse: assert property (
      stop_wake_signal |=> !stop_wake_signal)
      else $error("wake longer than one cycle");
   chk_wake_no_irq: assert property (
      $rose(stop_wake_signal) && !receive_interrupt_request
         |-> !receive_interrupt_request [*3])
      else $error("compare byte raised interrupt");
endmodule
bind spmw_port spmw_port_chk u_chk
(
   .core_clk                  (core_clk),
   .rst                       (rst),
   .reg_addr                  (reg_addr),
   .reg_wdata                 (reg_wdata),
   .reg_wr                    (reg_wr),
   .reg_rd                    (reg_rd),
   .sw_irq_set                (sw_irq_set),
   .serial_clock_pin_oe       (serial_clock_pin_oe),
   .serial_output_oe          (serial_output_oe),
   .receive_interrupt_request (receive_interrupt_request),
   .stop_wake_signal          (stop_wake_signal)
);
`default_nettype wire

// ===== test/spmw_far_end.sv
// Far-end serial device: master for slave frames, slave for master frames
`timescale 1ns/1ps
`default_nettype none
module spmw_far_end
(
   input  wire logic sk,
   input  wire logic sk_by_dut,
   input  wire logic dut_do,
   input  wire logic dut_do_oe,
   output var  logic sk_drv,
   output var  logic sel_n,
   output var  logic mosi
);
   logic [7:0] reply;
   logic [7:0] cap;
   logic       oe_seen;
   initial
   begin
      sk_drv = 1'b0;
      sel_n = 1'b1;
      mosi = 1'b1;
      reply = 8'h00;
      cap = 8'h00;
      oe_seen = 1'b0;
   end
   // Select low frames a byte, MSB first; clock idles at phase level
   task automatic frame(input logic [7:0] b, input logic ph);
      integer i;
      begin
         oe_seen = 1'b0;
         sk_drv = ph;
         sel_n = 1'b0;
         #800;
         for (i = 7; i >= 0; i = i - 1)
         begin
            mosi = b[i];
            #800;
            sk_drv = ~ph;
            oe_seen = oe_seen | dut_do_oe;
            #800;
            sk_drv = ph;
         end
         #800;
         sel_n = 1'b1;
         // Released line must not keep showing its last bit
         mosi = ~mosi;
         // Select stays high long enough to be seen between frames
         #800;
      end
   endtask
   task automatic load(input logic [7:0] r);
      begin
         reply = r;
         mosi = r[7];
      end
   endtask
   // Slave role when the port is master: sample rising, answer falling
   always @(posedge sk)
      if (sk_by_dut)
         cap <= {cap[6:0], dut_do};
   always @(negedge sk)
      if (sk_by_dut)
      begin
         mosi <= reply[6];
         reply <= {reply[6:0], ~reply[7]};
      end
endmodule
`default_nettype wire

// ===== test/spmw_port_bench.sv
// Self-checking bench for the serial port with match wake
`timescale 1ns/1ps
`default_nettype none
`define CHK(got, exp) check_val(8'(got), 8'(exp))
module spmw_port_bench;
   logic       core_clk, rst, reg_wr, reg_rd, sw_irq_set;
   logic       timer_clock, first_counter_timer;
   logic [7:0] reg_addr, reg_wdata, reg_rdata, b, m, e;
   logic       sk_out, sk_oe, do_pin, do_oe, irq, wake, sk_drv, sel_n;
   logic       mosi, rd_d, sk_p;
   wire        sk = sk_oe ? sk_out : sk_drv;
   integer     bad_count, total_checks, wake_cnt, gap, last_gap, i, k;
   logic [7:0] exp_q[$];
   spmw_port u_dut (.core_clk(core_clk), .rst(rst), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_rdata(reg_rdata), .timer_clock(timer_clock),
      .first_counter_timer(first_counter_timer), .sw_irq_set(sw_irq_set),
      .serial_input_pin(mosi), .select_n_pin(sel_n),
      .serial_clock_pin_in(sk), .serial_clock_pin_out(sk_out),
      .serial_clock_pin_oe(sk_oe), .serial_output_pin(do_pin),
      .serial_output_oe(do_oe), .receive_interrupt_request(irq),
      .stop_wake_signal(wake));
   spmw_far_end u_far (.sk(sk), .sk_by_dut(sk_oe), .dut_do(do_pin),
      .dut_do_oe(do_oe), .sk_drv(sk_drv), .sel_n(sel_n), .mosi(mosi));
   initial
   begin
      core_clk = 1'b0;
      forever #50 core_clk = ~core_clk;
   end
   task check_val(input logic [7:0] got, input logic [7:0] exp);
      begin
         total_checks = total_checks + 1;
         if (got !== exp)
         begin
            bad_count = bad_count + 1;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
         end
      end
   endtask
   task complete_run;
      begin
         $display("checks %0d mismatches %0d", total_checks, bad_count);
         if (bad_count == 0 && total_checks > 0)
            $display("Test passed");
         else
            $display("Test failed");
         $finish;
      end
   endtask
   task wr(input logic [7:0] a, input logic [7:0] d);
      begin
         reg_addr <= a;
         reg_wdata <= d;
         reg_wr <= 1'b1;
         @(posedge core_clk);
         reg_wr <= 1'b0;
         @(posedge core_clk);
      end
   endtask
   // Expected value goes on the queue; the monitor does the comparing
   task rd(input logic [7:0] a, input logic [7:0] x);
      begin
         exp_q.push_back(x);
         reg_addr <= a;
         reg_rd <= 1'b1;
         @(posedge core_clk);
         reg_rd <= 1'b0;
         @(posedge core_clk);
      end
   endtask
   task wait_irq;
      begin
         for (k = 0; k < 3000 && irq !== 1'b1; k = k + 1)
            @(posedge core_clk);
         `CHK(irq, 1'b1);
      end
   endtask
   // Two free-running clock sources, the second at half the rate of the first
   always @(posedge core_clk)
   begin
      timer_clock <= ~timer_clock;
      if (timer_clock)
         first_counter_timer <= ~first_counter_timer;
   end
   always @(posedge core_clk)
   begin
      if (rd_d)
      begin
         e = exp_q.pop_front();
         if (e !== 8'hXX)
            `CHK(reg_rdata, e);
      end
      rd_d = reg_rd;
      if (wake === 1'b1)
         wake_cnt = wake_cnt + 1;
      gap = gap + 1;
      if (sk_out !== sk_p)
      begin
         // Rise only: the closing fall after bit eight comes early
         if (sk_out === 1'b1)
            last_gap = gap;
         gap = 0;
      end
      sk_p = sk_out;
   end
   initial
   begin
      #2000000;
      bad_count = bad_count + 1;
      complete_run;
   end
   initial
   begin
      {rst, reg_wr, reg_rd, sw_irq_set, rd_d, sk_p} = 6'h20;
      {timer_clock, first_counter_timer, reg_addr, reg_wdata} = 18'h0;
      {bad_count, total_checks, wake_cnt, gap, last_gap} = 160'h0;
      void'($urandom(32'h1A08));
      repeat (3) @(posedge core_clk);
      rst <= 1'b0;
      @(posedge core_clk);
      rd(8'h02, 8'h00);
      rd(8'h03, 8'h00);
      rd(8'h10, 8'h00);
      $display("reset test done");
      sw_irq_set <= 1'b1;
      @(posedge core_clk);
      sw_irq_set <= 1'b0;
      repeat (2) @(posedge core_clk);
      `CHK(irq, 1'b1);
      rd(8'h04, 8'hXX);
      u_far.frame(8'($urandom), 1'b0);
      repeat (20) @(posedge core_clk);
      `CHK(irq, 1'b0);
      `CHK(u_far.oe_seen, 1'b0);
      $display("disabled test done");
      for (i = 0; i < 2; i = i + 1)
      begin
         b = 8'($urandom);
         wr(8'h02, {2'b00, i[0], 5'h01});
         u_far.frame(b, i[0]);
         @(posedge core_clk);
         wait_irq();
         rd(8'h02, {2'b00, i[0], 5'h11});
         rd(8'h04, b);
         `CHK(u_far.oe_seen, 1'b1);
         repeat (2) @(posedge core_clk);
         `CHK(irq, 1'b0);
      end
      $display("slave test done");
      wr(8'h02, 8'h01);
      b = 8'($urandom);
      u_far.frame(~b, 1'b0);
      u_far.frame(b, 1'b0);
      repeat (20) @(posedge core_clk);
      rd(8'h02, 8'h13);
      rd(8'h04, b);
      rd(8'h02, 8'h03);
      wr(8'h02, 8'h01);
      rd(8'h02, 8'h01);
      wr(8'h02, 8'h05);
      u_far.frame(~b, 1'b0);
      repeat (20) @(posedge core_clk);
      `CHK(u_far.oe_seen, 1'b0);
      rd(8'h04, ~b);
      $display("overrun test done");
      m = 8'($urandom);
      wr(8'h03, m);
      rd(8'h03, m);
      wr(8'h02, 8'h09);
      wake_cnt = 0;
      u_far.frame(m, 1'b0);
      repeat (20) @(posedge core_clk);
      `CHK(wake_cnt, 1);
      `CHK(irq, 1'b0);
      `CHK(u_far.oe_seen, 1'b0);
      u_far.frame(~m, 1'b0);
      repeat (20) @(posedge core_clk);
      `CHK(wake_cnt, 1);
      `CHK(irq, 1'b0);
      $display("compare test done");
      for (i = 0; i < 5; i = i + 1)
      begin
         b = 8'($urandom);
         m = 8'($urandom);
         u_far.load(m);
         wr(8'h02, (i == 4) ? 8'hC1 : {5'h10, i[1:0], 1'b1});
         wr(8'h04, b);
         wait_irq();
         rd(8'h04, m);
         `CHK(u_far.cap, b);
         `CHK(last_gap, (i == 4) ? 4 : 2 << i);
      end
      $display("master test done");
      complete_run;
   end
endmodule
`default_nettype wire
